// ---- verilog/utf_pkg.sv ----
// shared constants and types of the uart transmit framing block
package utf_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_HOLD = 8'h0c;
  localparam logic [7:0] ADDR_DIV = 8'h10;

  // serial_control_one fields
  localparam int C1_UNIT_ON = 0;
  localparam int C1_NINE = 1;
  localparam int C1_PAR_ON = 2;
  localparam int C1_PAR_ODD = 3;
  localparam int C1_TWO_STOP = 4;
  localparam int C1_NINTH = 5;
  localparam logic [7:0] C1_MASK = 8'h3f;

  // serial_control_two fields
  localparam int C2_TX_ON = 0;
  localparam int C2_RX_ON = 1;
  localparam int C2_HIGH = 2;
  localparam int C2_BREAK = 3;
  localparam int C2_IRQ_ON = 4;
  localparam logic [7:0] C2_MASK = 8'h1f;

  // serial_status fields
  localparam int ST_EMPTY = 0;
  localparam int ST_TX_QUIET = 1;
  localparam int ST_RX_QUIET = 2;

  // reset values: 8 data bits, no parity, one stop bit
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;

  // ****************************************************************
  // timing and framing
  // ****************************************************************
  localparam logic [5:0] PRE_LOW = 6'h3f;
  localparam logic [5:0] PRE_HIGH = 6'h0f;
  localparam int FRAME_W = 14;
  localparam int LEN_W = 4;
  localparam logic [LEN_W-1:0] BREAK_LEN = 4'he;

  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_BREAK, TX_TWO_STOP_SELECT} utf_tx_state_e;

endpackage

// ---- verilog/utf_shift_if.sv ----
// link between the transmit sequencer and the bit shifter
interface utf_shift_if;
  logic load;
  logic abort;
  logic tick;
  logic [utf_pkg::FRAME_W-1:0] frame;
  logic [utf_pkg::LEN_W-1:0] len;
  logic busy;
  logic done;
  logic line;

  modport seq (output load, output abort, output tick, output frame, output len,
               input busy, input done, input line);
  modport shifter (input load, input abort, input tick, input frame, input len,
                   output busy, output done, output line);
endinterface

// ---- verilog/utf_baud.sv ----
// baud generator: one tick per bit period
module utf_baud #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic run,
  input wire logic high_speed,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [5:0] pre_q;
  logic [DIV_W-1:0] div_q;
  logic [5:0] pre_lim;
  logic pre_wrap;

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("utf_baud: divisor width out of range");
    end
  endgenerate

  assign pre_lim = high_speed ? utf_pkg::PRE_HIGH : utf_pkg::PRE_LOW;
  assign pre_wrap = (pre_q >= pre_lim);
  // period is (prescale) * (divisor + 1) system clocks
  assign tick = run && pre_wrap && (div_q >= divisor);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
      div_q <= '0;
    end else if (clk_en) begin
      if (!run) begin
        pre_q <= 6'h00;
        div_q <= '0;
      end else if (pre_wrap) begin
        pre_q <= 6'h00;
        div_q <= tick ? '0 : div_q + 1'b1;
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

endmodule

// ---- verilog/utf_shifter.sv ----
// transmit shift register: sends a frame vector lsb first
module utf_shifter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  utf_shift_if.shifter sif
);

  logic [utf_pkg::FRAME_W-1:0] sh_q;
  logic [utf_pkg::LEN_W-1:0] cnt_q;
  logic busy_q;
  logic run_q;

  assign sif.busy = busy_q;
  assign sif.done = sif.tick && busy_q && run_q && (cnt_q == 4'h1);
  // line rests high whenever no bit is on the wire
  assign sif.line = run_q ? sh_q[0] : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= '1;
      cnt_q <= '0;
      busy_q <= 1'b0;
      run_q <= 1'b0;
    end else if (clk_en) begin
      if (sif.abort) begin
        sh_q <= '1;
        busy_q <= 1'b0;
        run_q <= 1'b0;
      end else if (sif.load) begin
        // a load on a tick starts at once so break characters stay contiguous
        sh_q <= sif.frame;
        cnt_q <= sif.len;
        busy_q <= 1'b1;
        run_q <= sif.tick;
      end else if (sif.tick && busy_q) begin
        if (!run_q) begin
          run_q <= 1'b1;
        end else if (cnt_q == 4'h1) begin
          busy_q <= 1'b0;
          run_q <= 1'b0;
        end else begin
          sh_q <= {1'b1, sh_q[utf_pkg::FRAME_W-1:1]};
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end

endmodule

// ---- verilog/uart_transmit_framing.sv ----
// uart transmit path with frame format, enables, flags and apb registers
//
// Behaviour
// - nrz frame: start, 8/9 data, 1/2 two_stop_select
// - parity even, odd or off
// - reset format is 8 data, none, 1
// - shared format and 8-bit baud generator
// - data leaves lsb first
// - baud clock / (64 or 16)(divisor+1)
// - idle transmit line held high
// - pins owned only when unit and direction on
// - unit off empties buffers, drops data
// - unit off clears enables, sets idle flags
// - unit off aborts; re-enable keeps configuration
// - nine-bit and two-stop selects independent
// - parity or address bit takes last position
// - ninth bit comes from control field
// - shifter reloads only after stop bits
// - send needs enable, data and baud tick
// - transmit off aborts and releases pin
// - holding-empty flag, optional interrupt
// - status access then write; blocked when full
// - write during frame waits in holding
// - write while idle goes straight out
// - quiet flag set when frame completes
// - quiet flag cleared like holding-empty
// - break: 14 zeros, repeat, then two_stop_select
//
// Implementation choices: the register addresses and the APB interface to the registers.
module uart_transmit_framing #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic tx_o,
  output logic tx_oe,
  output logic rx_claim,
  output logic tx_empty_irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0] hold_q;
  logic empty_q;
  logic quiet_q;
  logic seen_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic tx_q;
  logic tx_oe_q;
  utf_pkg::utf_tx_state_e tx_state_q;
  utf_pkg::utf_tx_state_e tx_state_d;
  logic acc;
  logic wr;
  logic rd;
  logic unit_on;
  logic tx_on;
  logic brk;
  logic hold_wr;
  logic unit_off_ev;
  logic ld_data;
  logic ld_break;
  logic ld_two_stop_select;
  logic frame_end;
  logic [utf_pkg::FRAME_W-1:0] data_frame;
  logic [utf_pkg::LEN_W-1:0] data_len;

  utf_shift_if sif ();

  generate
    if (DIV_W != 8) begin : g_bad_div
      $error("uart_transmit_framing: divisor register is 8 bits wide");
    end
  endgenerate

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, utf_pkg::ADDR_CTRL_ONE) || hit(a, utf_pkg::ADDR_CTRL_TWO) ||
             hit(a, utf_pkg::ADDR_STATUS) || hit(a, utf_pkg::ADDR_HOLD) ||
             hit(a, utf_pkg::ADDR_DIV);
  endfunction

  // builds start, data (with parity or ninth bit) and stop bits
  function automatic logic [utf_pkg::FRAME_W+utf_pkg::LEN_W-1:0] build(
    input logic [7:0] d, input logic [7:0] c1);
    logic [8:0] w;
    logic [utf_pkg::FRAME_W-1:0] f;
    logic [utf_pkg::LEN_W-1:0] n;
    w = {c1[utf_pkg::C1_NINTH], d};
    f = '1;
    if (c1[utf_pkg::C1_PAR_ON]) begin
      if (c1[utf_pkg::C1_NINE]) begin
        w[8] = (^w[7:0]) ^ c1[utf_pkg::C1_PAR_ODD];
      end else begin
        w[7] = (^w[6:0]) ^ c1[utf_pkg::C1_PAR_ODD];
      end
    end
    f[0] = 1'b0;
    if (c1[utf_pkg::C1_NINE]) begin
      f[9:1] = w;
    end else begin
      f[8:1] = w[7:0];
    end
    // stop bits are the ones left above the word
    n = c1[utf_pkg::C1_NINE] ? 4'hb : 4'ha;
    if (c1[utf_pkg::C1_TWO_STOP]) begin
      n = n + 4'h1;
    end
    build = {n, f};
  endfunction

  // ****************************************************************
  // apb slave: no wait states, registered answer
  // ****************************************************************
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = pready_q;
  assign pslverr = pready_q && pslverr_q;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q <= psel && !penable;
      pslverr_q <= !mapped(paddr);
      prdata_q <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, utf_pkg::ADDR_CTRL_ONE)) begin
          prdata_q <= {24'h00_0000, ctrl_one_q};
        end else if (hit(paddr, utf_pkg::ADDR_CTRL_TWO)) begin
          prdata_q <= {24'h00_0000, ctrl_two_q};
        end else if (hit(paddr, utf_pkg::ADDR_STATUS)) begin
          // receiver flags sit at their idle values here
          prdata_q <= {29'h0000_0000, 1'b1, quiet_q, empty_q};
        end else if (hit(paddr, utf_pkg::ADDR_DIV)) begin
          prdata_q <= {{(32-DIV_W){1'b0}}, div_q};
        end
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  assign unit_on = ctrl_one_q[utf_pkg::C1_UNIT_ON];
  assign tx_on = unit_on && ctrl_two_q[utf_pkg::C2_TX_ON];
  assign brk = ctrl_two_q[utf_pkg::C2_BREAK];
  assign unit_off_ev = wr && hit(paddr, utf_pkg::ADDR_CTRL_ONE) && unit_on &&
                       !pwdata[utf_pkg::C1_UNIT_ON];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_q <= utf_pkg::CTRL_ONE_RST;
      div_q <= utf_pkg::DIV_RST;
    end else if (clk_en && wr) begin
      // format and divisor survive a disable so re-enable resumes as before
      if (hit(paddr, utf_pkg::ADDR_CTRL_ONE)) begin
        ctrl_one_q <= pwdata[7:0] & utf_pkg::C1_MASK;
      end
      if (hit(paddr, utf_pkg::ADDR_DIV)) begin
        div_q <= pwdata[DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_two_q <= utf_pkg::CTRL_TWO_RST;
    end else if (clk_en) begin
      if (unit_off_ev) begin
        ctrl_two_q[utf_pkg::C2_TX_ON] <= 1'b0;
        ctrl_two_q[utf_pkg::C2_RX_ON] <= 1'b0;
        ctrl_two_q[utf_pkg::C2_BREAK] <= 1'b0;
      end else if (wr && hit(paddr, utf_pkg::ADDR_CTRL_TWO)) begin
        ctrl_two_q <= pwdata[7:0] & utf_pkg::C2_MASK;
      end
    end
  end

  // ****************************************************************
  // holding register and flags
  // ****************************************************************
  assign hold_wr = wr && hit(paddr, utf_pkg::ADDR_HOLD) && unit_on &&
                   empty_q && seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 8'h00;
    end else if (clk_en && hold_wr) begin
      hold_q <= pwdata[7:0];
    end
  end

  // status read arms the clearing sequence, an accepted write consumes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else if (clk_en) begin
      if (rd && hit(paddr, utf_pkg::ADDR_STATUS)) begin
        seen_q <= 1'b1;
      end else if (hold_wr) begin
        seen_q <= 1'b0;
      end
    end
  end

  // set wins over clear on both flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_q <= 1'b1;
    end else if (clk_en) begin
      if (!unit_on || ld_data) begin
        empty_q <= 1'b1;
      end else if (hold_wr) begin
        empty_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 1'b1;
    end else if (clk_en) begin
      if (!unit_on || frame_end) begin
        quiet_q <= 1'b1;
      end else if (hold_wr) begin
        quiet_q <= 1'b0;
      end
    end
  end

  // no transmit interrupt while a break is on the line
  assign tx_empty_irq = empty_q && ctrl_two_q[utf_pkg::C2_IRQ_ON] &&
                        (tx_state_q != utf_pkg::TX_BREAK);

  // ****************************************************************
  // transmit sequencer
  // ****************************************************************
  assign {data_len, data_frame} = build(hold_q, ctrl_one_q);
  assign frame_end = sif.done && (tx_state_q == utf_pkg::TX_DATA ||
                                  tx_state_q == utf_pkg::TX_TWO_STOP_SELECT ||
                                  (tx_state_q == utf_pkg::TX_BREAK && !brk));

  always_comb begin
    tx_state_d = tx_state_q;
    ld_data = 1'b0;
    ld_break = 1'b0;
    ld_two_stop_select = 1'b0;
    unique case (tx_state_q)
      utf_pkg::TX_IDLE: begin
        if (brk) begin
          ld_break = 1'b1;
        end else if (!empty_q) begin
          ld_data = 1'b1;
        end
      end
      utf_pkg::TX_DATA: begin
        if (sif.done) begin
          if (brk) begin
            ld_break = 1'b1;
          end else if (!empty_q) begin
            ld_data = 1'b1;
          end else begin
            tx_state_d = utf_pkg::TX_IDLE;
          end
        end
      end
      utf_pkg::TX_BREAK: begin
        if (sif.done) begin
          if (brk) begin
            ld_break = 1'b1;
          end else begin
            ld_two_stop_select = 1'b1;
          end
        end
      end
      utf_pkg::TX_TWO_STOP_SELECT: begin
        if (sif.done) begin
          tx_state_d = utf_pkg::TX_IDLE;
        end
      end
    endcase
    // a word written before the enable must wait in holding, not be dropped
    if (!tx_on) begin
      ld_data = 1'b0;
      ld_break = 1'b0;
      ld_two_stop_select = 1'b0;
    end
    if (ld_data) begin
      tx_state_d = utf_pkg::TX_DATA;
    end else if (ld_break) begin
      tx_state_d = utf_pkg::TX_BREAK;
    end else if (ld_two_stop_select) begin
      tx_state_d = utf_pkg::TX_TWO_STOP_SELECT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= utf_pkg::TX_IDLE;
    end else if (clk_en) begin
      tx_state_q <= tx_on ? tx_state_d : utf_pkg::TX_IDLE;
    end
  end

  assign sif.load = tx_on && (ld_data || ld_break || ld_two_stop_select);
  assign sif.abort = !tx_on;
  assign sif.frame = ld_data ? data_frame :
                     ld_break ? {utf_pkg::FRAME_W{1'b0}} : {utf_pkg::FRAME_W{1'b1}};
  assign sif.len = ld_data ? data_len :
                   ld_break ? utf_pkg::BREAK_LEN :
                   (ctrl_one_q[utf_pkg::C1_TWO_STOP] ? 4'h2 : 4'h1);

  utf_baud #(.DIV_W(DIV_W)) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .run(unit_on),
    .high_speed(ctrl_two_q[utf_pkg::C2_HIGH]),
    .divisor(div_q),
    .tick(sif.tick)
  );

  utf_shifter u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .sif(sif)
  );

  // ****************************************************************
  // pins
  // ****************************************************************
  assign tx_o = tx_q;
  assign tx_oe = tx_oe_q;
  assign rx_claim = unit_on && ctrl_two_q[utf_pkg::C2_RX_ON];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= 1'b1;
      tx_oe_q <= 1'b0;
    end else if (clk_en) begin
      tx_q <= tx_on ? sif.line : 1'b1;
      tx_oe_q <= tx_on;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  property p_blocked_write;
    wr && hit(paddr, utf_pkg::ADDR_HOLD) && !empty_q |=> $stable(hold_q);
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("holding write not blocked");

  property p_unit_off_flags;
    unit_off_ev |=> ##1 empty_q && quiet_q && !ctrl_two_q[utf_pkg::C2_TX_ON] &&
                    !ctrl_two_q[utf_pkg::C2_BREAK] && !tx_oe_q;
  endproperty
  a_unit_off_flags: assert property (p_unit_off_flags) else $error("disable side effects wrong");

  property p_release;
    !tx_on |=> !tx_oe_q && (tx_state_q == utf_pkg::TX_IDLE) && !sif.busy;
  endproperty
  a_release: assert property (p_release) else $error("transmitter not reset on disable");

  property p_idle_high;
    tx_oe_q && $past(!sif.busy && tx_on) |-> tx_q;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high");

  property p_parity8;
    ld_data && ctrl_one_q[utf_pkg::C1_PAR_ON] && !ctrl_one_q[utf_pkg::C1_NINE] |->
      (^sif.frame[8:1]) == ctrl_one_q[utf_pkg::C1_PAR_ODD];
  endproperty
  a_parity8: assert property (p_parity8) else $error("parity bit wrong");

  property p_frame_shape;
    ld_data |-> !sif.frame[0] && (sif.frame[1] == hold_q[0]) &&
      sif.len == (4'ha + {3'b000, ctrl_one_q[utf_pkg::C1_NINE]} +
                  {3'b000, ctrl_one_q[utf_pkg::C1_TWO_STOP]});
  endproperty
  a_frame_shape: assert property (p_frame_shape) else $error("frame layout wrong");

  property p_break_frame;
    ld_break |-> (sif.frame == '0) && (sif.len == utf_pkg::BREAK_LEN);
  endproperty
  a_break_frame: assert property (p_break_frame) else $error("break frame wrong");

  property p_straight_out;
    hold_wr && tx_on && !brk && (tx_state_q == utf_pkg::TX_IDLE) |=>
      ld_data ##1 empty_q;
  endproperty
  a_straight_out: assert property (p_straight_out) else $error("idle write not sent");

  property p_quiet_set;
    frame_end |=> quiet_q;
  endproperty
  a_quiet_set: assert property (p_quiet_set) else $error("quiet flag not set");

  property p_reload_after_stop;
    sif.load && (tx_state_q != utf_pkg::TX_IDLE) |-> sif.done;
  endproperty
  a_reload_after_stop: assert property (p_reload_after_stop) else $error("early reload");

  c_data_frame: cover property (ld_data ##[1:1000] frame_end);
  c_break_then_two_stop_select: cover property (ld_break ##[1:1000] ld_two_stop_select);
  c_back_to_back: cover property (sif.done && ld_data && tx_state_q == utf_pkg::TX_DATA);

endmodule

// ---- verification/utf_remote_rx.sv ----
// remote serial receiver model that samples the transmit line
module utf_remote_rx (
  input logic pclk,
  input logic tx_o,
  input logic tx_oe,
  input int period,
  input int nbits,
  output logic [11:0] frame_q,
  output int count_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] f;
  // ****************************************************************
  // listener: waits for a start edge, samples each bit mid-period
  // ****************************************************************
  initial begin
    count_q = 0;
    frame_q = '1;
    forever begin
      @(posedge pclk);
      // only a driven line counts; a released pin is not a start bit
      if (tx_oe === 1'b1 && tx_o === 1'b0) begin
        f = '1;
        repeat (period / 2) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
          if (i > 0) repeat (period) @(posedge pclk);
          f[i] = tx_o;
        end
        // no wait after the last stop, so a back-to-back start is caught
        frame_q = f;
        count_q++;
      end
    end
  end
endmodule

// ---- verification/uart_transmit_framing_tb.sv ----
// self-checking bench for the uart transmit framing block
module uart_transmit_framing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] c1; logic [7:0] c2; logic [7:0] div; logic [7:0] d;} utf_row_s;
  // ****************************************************************
  // clock, dut and far side
  // ****************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, tx_o, tx_oe, rx_claim, tx_empty_irq, rerr;
  logic [11:0] rx_frame;
  int rx_count, n, k;
  int period = 16;
  int nbits = 10;
  int num_errors = 0;
  int checked = 0;
  time t0;
  utf_row_s rows [6] = '{'{8'h01, 8'h05, 8'h00, 8'ha5}, '{8'h05, 8'h07, 8'h01, 8'h3c},
    '{8'h0d, 8'h05, 8'h00, 8'h81}, '{8'h13, 8'h05, 8'h00, 8'h5a},
    '{8'h33, 8'h01, 8'h00, 8'hc3}, '{8'h07, 8'h05, 8'h02, 8'hff}};

  always #20 pclk = ~pclk;

  // clock enable tied on: freezing is not exercised here
  uart_transmit_framing u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_o(tx_o), .tx_oe(tx_oe), .rx_claim(rx_claim),
    .tx_empty_irq(tx_empty_irq));
  utf_remote_rx u_far (.pclk(pclk), .tx_o(tx_o), .tx_oe(tx_oe), .period(period),
    .nbits(nbits), .frame_q(rx_frame), .count_q(rx_count));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("mismatches %0d of %0d compares", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    j = 0;
    do begin
      @(posedge pclk);
      j++;
    end while (pready !== 1'b1 && j < 20);
    check(pready, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // later checks then see what the write has just changed
    @(negedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask

  // the holding write only lands after a status access
  task automatic send(input logic [7:0] d);
    apb(1'b0, utf_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, utf_pkg::ADDR_HOLD, {24'h0, d});
  endtask

  task automatic wait_frames(input int target);
    int j;
    j = 0;
    while (rx_count < target && j < 2000) begin
      @(posedge pclk);
      j++;
    end
    check(rx_count, target);
  endtask

  function automatic logic [11:0] exp_frame(input logic [7:0] c1, input logic [7:0] d);
    logic [11:0] f;
    logic [8:0] w;
    logic p;
    int m;
    w = {c1[5], d};
    m = c1[1] ? 9 : 8;
    f = {2'b11, w, 1'b0};
    if (m == 8) f[9] = 1'b1;
    p = c1[3];
    for (int i = 0; i < m - 1; i++) p ^= w[i];
    if (c1[2]) f[m] = p;
    return f;
  endfunction

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge pclk);
    check({tx_o, tx_oe, rx_claim}, 3'b100);
    presetn <= 1'b1;
    rdchk(utf_pkg::ADDR_CTRL_ONE, 32'h0);
    rdchk(utf_pkg::ADDR_CTRL_TWO, 32'h0);
    rdchk(utf_pkg::ADDR_DIV, 32'h0);
    rdchk(utf_pkg::ADDR_STATUS, 32'h7);
    apb(1'b0, 8'h14, 32'h0);
    check(rerr, 1'b1);
    foreach (rows[i]) begin
      apb(1'b1, utf_pkg::ADDR_CTRL_ONE, {24'h0, rows[i].c1});
      apb(1'b1, utf_pkg::ADDR_CTRL_TWO, {24'h0, rows[i].c2});
      apb(1'b1, utf_pkg::ADDR_DIV, {24'h0, rows[i].div});
      period = (rows[i].c2[2] ? 16 : 64) * (rows[i].div + 1);
      nbits = 2 + (rows[i].c1[1] ? 9 : 8) + rows[i].c1[4];
      send(rows[i].d);
      rdchk(utf_pkg::ADDR_STATUS, 32'h5);
      wait_frames(i + 1);
      check(rx_frame, exp_frame(rows[i].c1, rows[i].d));
      repeat (period) @(posedge pclk);
      rdchk(utf_pkg::ADDR_STATUS, 32'h7);
      check(tx_o, 1'b1);
    end
    // two writes during one frame, a third refused while holding is full
    apb(1'b1, utf_pkg::ADDR_CTRL_ONE, 32'h01);
    apb(1'b1, utf_pkg::ADDR_DIV, 32'h0);
    period = 16;
    nbits = 10;
    n = rx_count;
    send(8'h11);
    send(8'h22);
    rdchk(utf_pkg::ADDR_STATUS, 32'h4);
    send(8'h33);
    wait_frames(n + 1);
    check(rx_frame, exp_frame(8'h01, 8'h11));
    wait_frames(n + 2);
    check(rx_frame, exp_frame(8'h01, 8'h22));
    repeat (400) @(posedge pclk);
    check(rx_count, n + 2);
    // unit off in mid-frame, then data loaded before the enable
    apb(1'b1, utf_pkg::ADDR_CTRL_TWO, 32'h17);
    check({rx_claim, tx_empty_irq}, 2'b11);
    apb(1'b1, utf_pkg::ADDR_CTRL_ONE, 32'h11);
    nbits = 11;
    send(8'h96);
    repeat (40) @(posedge pclk);
    apb(1'b1, utf_pkg::ADDR_CTRL_ONE, 32'h10);
    repeat (2) @(posedge pclk);
    check({tx_oe, tx_o, rx_claim}, 3'b010);
    rdchk(utf_pkg::ADDR_CTRL_TWO, 32'h14);
    rdchk(utf_pkg::ADDR_CTRL_ONE, 32'h10);
    rdchk(utf_pkg::ADDR_STATUS, 32'h7);
    repeat (200) @(posedge pclk);
    apb(1'b1, utf_pkg::ADDR_CTRL_ONE, 32'h11);
    n = rx_count;
    send(8'h96);
    apb(1'b1, utf_pkg::ADDR_CTRL_TWO, 32'h05);
    wait_frames(n + 1);
    check(rx_frame, exp_frame(8'h11, 8'h96));
    // transmit off in mid-frame
    send(8'h0f);
    repeat (40) @(posedge pclk);
    apb(1'b1, utf_pkg::ADDR_CTRL_TWO, 32'h04);
    repeat (2) @(posedge pclk);
    check({tx_oe, tx_o}, 2'b01);
    repeat (200) @(posedge pclk);
    // one break character: start plus 13 zeros, then two_stop_select
    apb(1'b1, utf_pkg::ADDR_CTRL_TWO, 32'h1d);
    k = 0;
    while (tx_o !== 1'b0 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    t0 = $time;
    check(tx_empty_irq, 1'b0);
    apb(1'b1, utf_pkg::ADDR_CTRL_TWO, 32'h15);
    while (tx_o === 1'b0 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    check(($time - t0) / 40, 14 * 16);
    repeat (32) @(posedge pclk);
    check({tx_o, tx_empty_irq}, 2'b11);
    print_verdict();
  end
endmodule
